// file: inc/snpc_pkg.sv
// Purpose: shared constants and types of the bus notify and pin-control block
// Assumes: 10 MHz system clock, 8-bit IO port, 32-bit sideband port
// Notes: IO and sideband offsets are separate spaces, so 10h appears twice
package snpc_pkg;
   // system clock and slow status domain
   localparam int SYS_CLK_HZ = 10_000_000;
   localparam int SLOW_CLK_HZ = 64_000;
   localparam int SLOW_TICK_DIV = SYS_CLK_HZ / SLOW_CLK_HZ;

   // IO register offsets (byte addresses)
   localparam logic [7:0] OFS_PIN_CTL = 8'h0F;
   localparam logic [7:0] OFS_NOTIFY_STS = 8'h10;
   localparam logic [7:0] OFS_NOTIFY_CMD = 8'h11;
   localparam logic [7:0] OFS_NOTIFIER_ADDR = 8'h14;
   localparam logic [7:0] OFS_NOTIFY_LOW = 8'h16;
   localparam logic [7:0] OFS_NOTIFY_HIGH = 8'h17;

   // sideband private register offsets (dword aligned)
   localparam logic [7:0] OFS_WDT_CFG = 8'h00;
   localparam logic [7:0] OFS_GEN_CTL = 8'h0C;
   localparam logic [7:0] OFS_PWR_CTL = 8'h10;

   // field positions
   localparam int BIT_CLK_OVR = 2;
   localparam int BIT_DATA_LVL = 1;
   localparam int BIT_CLK_LVL = 0;
   localparam int BIT_NOTIFY_FLAG = 0;
   localparam int BIT_ALERT_BLOCK = 2;
   localparam int BIT_NOTIFY_WAKE = 1;
   localparam int BIT_NOTIFY_IRQ = 0;
   localparam int BIT_WDT_IRQ_EN = 7;
   localparam int BIT_FUNC_OFF = 0;
   localparam int BIT_SLEEP_ALLOW = 3;
   localparam int BIT_HOT_GATE = 2;
   localparam int BIT_DEEP_IDLE = 1;
   localparam int BIT_PG_REQ_EN = 0;

   // reset values
   localparam logic [7:0] RST_PIN_CTL = 8'h04;
   localparam logic [2:0] RST_NOTIFY_CMD = 3'h0;
   localparam logic [31:0] RST_WDT_CFG = 32'h0000_0000;
   localparam logic [31:0] RST_GEN_CTL = 32'h0000_0000;
   localparam logic [31:0] RST_PWR_CTL = 32'h0000_0009;

   // notify message: host address with write bit, and byte count
   localparam logic [7:0] HOST_ADDR_BYTE = 8'h10;
   localparam logic [2:0] NOTIFY_BYTES = 3'h4;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // receiver states
   typedef enum logic [3:0] {
      SNPC_RX_IDLE = 4'h1,
      SNPC_RX_BITS = 4'h2,
      SNPC_RX_ACK = 4'h4,
      SNPC_RX_SKIP = 4'h8
   } snpc_rx_t;

   // whole state of the block
   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic [1:0] alert_s;
      logic scl_p;
      logic sda_p;
      logic [7:0] tick_cnt;
      logic clk_ovr_n;
      logic notify_flag;
      logic [2:0] cmd;
      logic sts_pend;
      logic cmd_pend;
      logic [2:0] cmd_val;
      logic [6:0] naddr;
      logic [7:0] nlow;
      logic [7:0] nhigh;
      logic [6:0] tmp_addr;
      logic [7:0] tmp_low;
      logic [7:0] tmp_high;
      snpc_rx_t rx;
      logic [3:0] bitcnt;
      logic [2:0] bytecnt;
      logic [7:0] shreg;
      logic wdt_en;
      logic func_off;
      logic sleep_allow;
      logic pg_en;
      logic [7:0] io_rdata;
      logic [31:0] sb_rdata;
      logic scl_oe;
      logic sda_oe;
      logic irq_b;
      logic smi_n;
      logic wake_flag;
      logic [7:0] wdt_lines;
      logic cfg_dis;
      logic pg_req;
      logic sleep;
   } snpc_state_t;
endpackage

// file: hdl/snpc_top.sv
// Purpose: notify receiver, pin control and sideband controls of a system bus controller
// Assumes: pins and alert are asynchronous; io and sideband strobes are on clk_sys
// Notes: status and command writes land on the next 64 kHz tick
`timescale 1ns/100ps

// Functional notes
// - override bit low forces clock pin low
// - pin register bit 1 shows data level
// - pin register bit 0 shows clock level
// - pin register reset only by resume reset
// - flag set after complete successful notify
// - write one clears flag, zero ignored
// - flag set: refuse host address byte
// - captured bytes held until flag cleared
// - alert request is status and not block
// - notify wake ORed into bus wake flag
// - notify interrupt is flag and enable
// - route interrupt to line b or mgmt
// - notifier address in bits 7:1, bit0 zero
// - first data byte at offset 16h
// - second data byte at offset 17h
// - watchdog enable gates selected irq line
// - general control bit 0 disables config
// - sleep only when sleep allow set
// - power gate request when enabled, idle and conditions met
// - power bits 2 and 1 read zero
module snpc_top #(
   parameter int TICK_DIV = snpc_pkg::SLOW_TICK_DIV
) (
   // clock and resets
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic resume_well_rst_n,
   // io register port
   input wire logic [7:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // sideband register port
   input wire logic [7:0] sb_addr,
   input wire logic sb_wr,
   input wire logic sb_rd,
   input wire logic [31:0] sb_wdata,
   output logic [31:0] sb_rdata,
   // bus pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic alert_n_i,
   // interrupt, wake and watchdog
   input wire logic mgmt_irq_route_sel,
   output logic shared_irq_line_b,
   output logic system_mgmt_irq_n,
   input wire logic other_wake_evt,
   input wire logic bus_wake_clr,
   output logic bus_wake_flag,
   input wire logic watchdog_evt,
   input wire logic [2:0] watchdog_irq_select,
   output logic [7:0] watchdog_irq_lines,
   // function and power control
   output logic cfg_space_disable,
   input wire logic pg_conditions_met,
   output logic power_gate_req,
   output logic sleep_assert
);
   snpc_pkg::snpc_state_t s_q;
   snpc_pkg::snpc_state_t s_d;

   // divider register is 8 bits wide and must wrap at least once
   if (TICK_DIV < 2 || TICK_DIV > 256) begin
      $error("snpc_top: TICK_DIV out of range");
   end

   localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);

   // helper terms read by the single combinational process
   logic scl_lvl;
   logic sda_lvl;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic tick;
   logic [7:0] rx_byte;
   logic alert_req;
   logic notify_irq;
   logic any_irq;
   logic rx_idle;

   // only second synchroniser stages are looked at
   assign scl_lvl = s_q.scl_s[1];
   assign sda_lvl = s_q.sda_s[1];
   assign scl_rise = scl_lvl & ~s_q.scl_p;
   assign scl_fall = ~scl_lvl & s_q.scl_p;
   assign start_cond = s_q.scl_p & scl_lvl & s_q.sda_p & ~sda_lvl;
   assign stop_cond = s_q.scl_p & scl_lvl & ~s_q.sda_p & sda_lvl;
   assign tick = (s_q.tick_cnt == TICK_LAST);
   assign rx_byte = s_q.shreg;

   // interrupt sources, alert status is the synced active-low pin
   assign alert_req = s_q.alert_s[1] == 1'b0 && !s_q.cmd[snpc_pkg::BIT_ALERT_BLOCK];
   assign notify_irq = s_q.notify_flag & s_q.cmd[snpc_pkg::BIT_NOTIFY_IRQ];
   assign any_irq = notify_irq | alert_req;
   assign rx_idle = (s_q.rx == snpc_pkg::SNPC_RX_IDLE) && !s_q.sts_pend && !s_q.cmd_pend;

   // next-state logic for the whole block
   always_comb begin
      logic notify_done;
      logic wake_set;
      notify_done = 1'b0;
      wake_set = 1'b0;
      s_d = s_q;

      // synchronisers and edge history
      s_d.scl_s = {s_q.scl_s[0], scl_i};
      s_d.sda_s = {s_q.sda_s[0], sda_i};
      s_d.alert_s = {s_q.alert_s[0], alert_n_i};
      s_d.scl_p = scl_lvl;
      s_d.sda_p = sda_lvl;

      // 64 kHz tick for the slow status domain
      s_d.tick_cnt = tick ? 8'h00 : s_q.tick_cnt + 8'h01;

      // io writes; slow-domain registers only queue the write
      if (io_wr) begin
         case (io_addr)
            snpc_pkg::OFS_PIN_CTL: begin
               // resume well register, nrst leaves it alone
               s_d.clk_ovr_n = io_wdata[snpc_pkg::BIT_CLK_OVR];
            end
            snpc_pkg::OFS_NOTIFY_STS: begin
               if (io_wdata[snpc_pkg::BIT_NOTIFY_FLAG]) begin
                  s_d.sts_pend = 1'b1;
               end
            end
            snpc_pkg::OFS_NOTIFY_CMD: begin
               s_d.cmd_pend = 1'b1;
               s_d.cmd_val = io_wdata[2:0];
            end
            default: begin
            end
         endcase
      end

      // queued writes take effect on the slow tick, software polls for it
      if (tick && s_q.cmd_pend) begin
         s_d.cmd = s_q.cmd_val;
         s_d.cmd_pend = 1'b0;
      end
      if (tick && s_q.sts_pend) begin
         s_d.notify_flag = 1'b0;
         s_d.sts_pend = 1'b0;
      end

      // notify message receiver
      case (s_q.rx)
         snpc_pkg::SNPC_RX_IDLE: begin
            s_d.sda_oe = 1'b0;
         end
         snpc_pkg::SNPC_RX_BITS: begin
            if (scl_rise && s_q.bitcnt != snpc_pkg::BITS_PER_BYTE) begin
               s_d.shreg = {s_q.shreg[6:0], sda_lvl};
               s_d.bitcnt = s_q.bitcnt + 4'h1;
            end else if (scl_fall && s_q.bitcnt == snpc_pkg::BITS_PER_BYTE) begin
               // decide on acknowledge of the byte just shifted in
               s_d.rx = snpc_pkg::SNPC_RX_ACK;
               s_d.sda_oe = 1'b1;
               s_d.bytecnt = s_q.bytecnt + 3'h1;
               case (s_q.bytecnt)
                  3'h0: begin
                     // busy flag refuses a new message at the host address
                     if (rx_byte != snpc_pkg::HOST_ADDR_BYTE || s_q.notify_flag) begin
                        s_d.rx = snpc_pkg::SNPC_RX_SKIP;
                        s_d.sda_oe = 1'b0;
                     end
                  end
                  3'h1: s_d.tmp_addr = rx_byte[7:1];
                  3'h2: s_d.tmp_low = rx_byte;
                  3'h3: s_d.tmp_high = rx_byte;
                  default: begin
                     // too many bytes: not a notify message
                     s_d.rx = snpc_pkg::SNPC_RX_SKIP;
                     s_d.sda_oe = 1'b0;
                  end
               endcase
            end
         end
         snpc_pkg::SNPC_RX_ACK: begin
            // hold data low for one whole clock high phase
            // the sender samples the ack while the clock is high
            if (scl_fall) begin
               s_d.sda_oe = 1'b0;
               s_d.bitcnt = 4'h0;
               s_d.rx = snpc_pkg::SNPC_RX_BITS;
            end
         end
         snpc_pkg::SNPC_RX_SKIP: begin
            s_d.sda_oe = 1'b0;
         end
         default: begin
            s_d.rx = snpc_pkg::SNPC_RX_IDLE;
            s_d.sda_oe = 1'b0;
         end
      endcase

      // stop ends any message; a full one is committed
      // the clock rise ahead of a stop counts as one bit,
      // so a clean end shows exactly one bit of a fresh byte
      if (stop_cond) begin
         if (s_q.rx == snpc_pkg::SNPC_RX_BITS && s_q.bytecnt == snpc_pkg::NOTIFY_BYTES &&
             s_q.bitcnt == 4'h1) begin
            notify_done = 1'b1;
         end
         s_d.rx = snpc_pkg::SNPC_RX_IDLE;
         s_d.sda_oe = 1'b0;
      end

      // start or repeated start opens a fresh message
      if (start_cond) begin
         s_d.rx = snpc_pkg::SNPC_RX_BITS;
         s_d.bitcnt = 4'h0;
         s_d.bytecnt = 3'h0;
         s_d.sda_oe = 1'b0;
      end

      // capture only while flag is clear; set wins over a queued clear
      // a notify refused at its first byte never gets this far
      if (notify_done && !s_q.notify_flag) begin
         s_d.naddr = s_q.tmp_addr;
         s_d.nlow = s_q.tmp_low;
         s_d.nhigh = s_q.tmp_high;
         s_d.notify_flag = 1'b1;
         s_d.sts_pend = 1'b0;
         wake_set = s_q.cmd[snpc_pkg::BIT_NOTIFY_WAKE];
      end

      // bus wake status, set wins over clear
      if (bus_wake_clr) begin
         s_d.wake_flag = 1'b0;
      end
      if (wake_set || other_wake_evt) begin
         s_d.wake_flag = 1'b1;
      end

      // sideband writes, only dword aligned offsets decode
      if (sb_wr && sb_addr[1:0] == 2'b00) begin
         case (sb_addr)
            snpc_pkg::OFS_WDT_CFG: s_d.wdt_en = sb_wdata[snpc_pkg::BIT_WDT_IRQ_EN];
            snpc_pkg::OFS_GEN_CTL: s_d.func_off = sb_wdata[snpc_pkg::BIT_FUNC_OFF];
            snpc_pkg::OFS_PWR_CTL: begin
               s_d.sleep_allow = sb_wdata[snpc_pkg::BIT_SLEEP_ALLOW];
               s_d.pg_en = sb_wdata[snpc_pkg::BIT_PG_REQ_EN];
            end
            default: begin
            end
         endcase
      end

      // io read data, unmapped offsets read zero
      s_d.io_rdata = 8'h00;
      if (io_rd) begin
         case (io_addr)
            snpc_pkg::OFS_PIN_CTL: begin
               s_d.io_rdata[snpc_pkg::BIT_CLK_OVR] = s_q.clk_ovr_n;
               s_d.io_rdata[snpc_pkg::BIT_DATA_LVL] = sda_lvl;
               s_d.io_rdata[snpc_pkg::BIT_CLK_LVL] = scl_lvl;
            end
            snpc_pkg::OFS_NOTIFY_STS: s_d.io_rdata[snpc_pkg::BIT_NOTIFY_FLAG] = s_q.notify_flag;
            snpc_pkg::OFS_NOTIFY_CMD: s_d.io_rdata[2:0] = s_q.cmd;
            snpc_pkg::OFS_NOTIFIER_ADDR: s_d.io_rdata = {s_q.naddr, 1'b0};
            snpc_pkg::OFS_NOTIFY_LOW: s_d.io_rdata = s_q.nlow;
            snpc_pkg::OFS_NOTIFY_HIGH: s_d.io_rdata = s_q.nhigh;
            default: s_d.io_rdata = 8'h00;
         endcase
      end

      // sideband read data, unsupported gating modes read zero
      s_d.sb_rdata = 32'h0000_0000;
      if (sb_rd && sb_addr[1:0] == 2'b00) begin
         case (sb_addr)
            snpc_pkg::OFS_WDT_CFG: s_d.sb_rdata[snpc_pkg::BIT_WDT_IRQ_EN] = s_q.wdt_en;
            snpc_pkg::OFS_GEN_CTL: s_d.sb_rdata[snpc_pkg::BIT_FUNC_OFF] = s_q.func_off;
            snpc_pkg::OFS_PWR_CTL: begin
               s_d.sb_rdata[snpc_pkg::BIT_SLEEP_ALLOW] = s_q.sleep_allow;
               s_d.sb_rdata[snpc_pkg::BIT_HOT_GATE] = 1'b0;
               s_d.sb_rdata[snpc_pkg::BIT_DEEP_IDLE] = 1'b0;
               s_d.sb_rdata[snpc_pkg::BIT_PG_REQ_EN] = s_q.pg_en;
            end
            default: s_d.sb_rdata = 32'h0000_0000;
         endcase
      end

      // registered outputs
      s_d.scl_oe = ~s_d.clk_ovr_n;
      s_d.irq_b = any_irq & ~mgmt_irq_route_sel;
      s_d.smi_n = ~(any_irq & mgmt_irq_route_sel);
      s_d.wdt_lines = s_q.wdt_en && watchdog_evt ? 8'h01 << watchdog_irq_select : 8'h00;
      s_d.cfg_dis = s_q.func_off;
      s_d.pg_req = s_q.pg_en & rx_idle & pg_conditions_met;
      s_d.sleep = s_q.pg_en & rx_idle & pg_conditions_met & s_q.sleep_allow;

      // resets: resume well keeps the pin register across system reset
      if (!nrst) begin
         // presets match the idle bus, so no false edge follows reset
         s_d.scl_s = 2'b11;
         s_d.sda_s = 2'b11;
         s_d.alert_s = 2'b11;
         s_d.scl_p = 1'b1;
         s_d.sda_p = 1'b1;
         s_d.tick_cnt = 8'h00;
         s_d.notify_flag = 1'b0;
         s_d.cmd = snpc_pkg::RST_NOTIFY_CMD;
         s_d.sts_pend = 1'b0;
         s_d.cmd_pend = 1'b0;
         s_d.cmd_val = 3'h0;
         s_d.naddr = 7'h00;
         s_d.nlow = 8'h00;
         s_d.nhigh = 8'h00;
         s_d.tmp_addr = 7'h00;
         s_d.tmp_low = 8'h00;
         s_d.tmp_high = 8'h00;
         s_d.rx = snpc_pkg::SNPC_RX_IDLE;
         s_d.bitcnt = 4'h0;
         s_d.bytecnt = 3'h0;
         s_d.shreg = 8'h00;
         s_d.wdt_en = snpc_pkg::RST_WDT_CFG[snpc_pkg::BIT_WDT_IRQ_EN];
         s_d.func_off = snpc_pkg::RST_GEN_CTL[snpc_pkg::BIT_FUNC_OFF];
         s_d.sleep_allow = snpc_pkg::RST_PWR_CTL[snpc_pkg::BIT_SLEEP_ALLOW];
         s_d.pg_en = snpc_pkg::RST_PWR_CTL[snpc_pkg::BIT_PG_REQ_EN];
         s_d.io_rdata = 8'h00;
         s_d.sb_rdata = 32'h0000_0000;
         s_d.sda_oe = 1'b0;
         s_d.irq_b = 1'b0;
         s_d.smi_n = 1'b1;
         s_d.wake_flag = 1'b0;
         s_d.wdt_lines = 8'h00;
         s_d.cfg_dis = 1'b0;
         s_d.pg_req = 1'b0;
         s_d.sleep = 1'b0;
      end
      if (!resume_well_rst_n) begin
         s_d.clk_ovr_n = snpc_pkg::RST_PIN_CTL[snpc_pkg::BIT_CLK_OVR];
         s_d.scl_oe = 1'b0;
      end
   end

   // single state register, resets are folded in above
   // both resets are synchronous, so no reset branch here
   always_ff @(posedge clk_sys) begin
      s_q <= s_d;
   end

   // every output except scl_o and sda_o straight from the state register
   assign io_rdata = s_q.io_rdata;
   assign sb_rdata = s_q.sb_rdata;
   assign scl_o = 1'b0; // open drain: only ever pulls low
   assign scl_oe = s_q.scl_oe;
   assign sda_o = 1'b0;
   assign sda_oe = s_q.sda_oe;
   assign shared_irq_line_b = s_q.irq_b;
   assign system_mgmt_irq_n = s_q.smi_n;
   assign bus_wake_flag = s_q.wake_flag;
   assign watchdog_irq_lines = s_q.wdt_lines;
   assign cfg_space_disable = s_q.cfg_dis;
   assign power_gate_req = s_q.pg_req;
   assign sleep_assert = s_q.sleep;
endmodule

// file: tb/snpc_assertions.sv
// Purpose: port checks of the notify and pin-control block
// Assumes: one clock domain, nrst synchronous active low
// Notes: registered outputs get one spare cycle
`timescale 1ns/100ps
module snpc_assertions #(
   parameter int TICK_DIV = 4
) (
   // clock and resets
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic resume_well_rst_n,
   // register ports
   input wire logic [7:0] io_addr,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] sb_addr,
   input wire logic sb_wr,
   input wire logic sb_rd,
   input wire logic [31:0] sb_wdata,
   input wire logic [31:0] sb_rdata,
   // pins and outputs
   input wire logic scl_o,
   input wire logic sda_o,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic shared_irq_line_b,
   input wire logic system_mgmt_irq_n,
   input wire logic watchdog_evt,
   input wire logic [2:0] watchdog_irq_select,
   input wire logic [7:0] watchdog_irq_lines,
   input wire logic cfg_space_disable,
   input wire logic pg_conditions_met,
   input wire logic power_gate_req,
   input wire logic sleep_assert
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // pin-control write outside resume reset
   wire pin_wr = io_wr && io_addr == snpc_pkg::OFS_PIN_CTL && resume_well_rst_n;
   clk_ovr_a: assert property (pin_wr && !io_wdata[2] |-> ##[1:2] scl_oe)
      else $error("override low did not pull clock");
   clk_rel_a: assert property (pin_wr && io_wdata[2] |-> ##[1:2] !scl_oe)
      else $error("override high did not release clock");
   open_drain_a: assert property (!scl_o && !sda_o)
      else $error("pin driven high");
   route_excl_a: assert property (!(shared_irq_line_b && !system_mgmt_irq_n))
      else $error("interrupt on both routes");
   wdt_line_a: assert property (watchdog_irq_lines != 8'h00 |->
      $past(watchdog_evt) && watchdog_irq_lines == (8'h01 << $past(watchdog_irq_select)))
      else $error("watchdog line wrong");
   func_off_a: assert property (sb_wr && sb_addr == 8'h0C && sb_wdata[0] |-> ##[1:2] cfg_space_disable)
      else $error("function disable not applied");
   sleep_gate_a: assert property (sleep_assert |-> power_gate_req)
      else $error("sleep without power gating");
   pg_cond_a: assert property (power_gate_req |-> $past(pg_conditions_met))
      else $error("power gate without conditions");
   sb_read_a: assert property (sb_rdata != 32'h0 |-> $past(sb_rd) && $past(sb_addr[1:0]) == 2'h0)
      else $error("sideband data without aligned read");
   // main scenarios reached
   cover property (scl_oe);
   cover property ($rose(sda_oe));
   cover property (sleep_assert);
endmodule

// file: tb/snpc_bus_dev.sv
// Purpose: bus device sending notify messages
// Assumes: pull-ups on both lines, 800 ns clock period
// Notes: clock stands high between frames
`timescale 1ns/100ps
module snpc_bus_dev (
   // open-drain pulls
   output logic scl_low,
   output logic sda_low,
   // resolved data line
   input wire logic sda
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // byte msb first, acknowledge sampled mid high phase
   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low = !b[i];
         #200 scl_low = 1'b0;
         #400 scl_low = 1'b1;
         #200;
      end
      sda_low = 1'b0;
      #200 scl_low = 1'b0;
      #200 ack = !sda;
      #200 scl_low = 1'b1;
      #200;
   endtask
   // whole message, stops at the first refused byte
   task automatic send(input logic [7:0] m [4], output int acks);
      logic ack;
      acks = 0;
      sda_low = 1'b1;
      #400 scl_low = 1'b1;
      #200;
      for (int k = 0; k < 4; k++) begin
         put_byte(m[k], ack);
         if (ack !== 1'b1) break;
         acks++;
      end
      sda_low = 1'b1;
      #200 scl_low = 1'b0;
      #200 sda_low = 1'b0;
      #400;
   endtask
endmodule

// file: tb/tb_smbus_notify_pin_ctl.sv
// Purpose: self-checking bench of the notify and pin-control block
// Assumes: short slow tick, inputs driven at falling edge
// Notes: slow writes are given two ticks to land
`timescale 1ns/100ps
module tb_smbus_notify_pin_ctl;
   localparam int TDIV = 4;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic rsm_n = 1'b0;
   logic [7:0] io_addr = 8'h00;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] io_rdata;
   logic [7:0] sb_addr = 8'h00;
   logic sb_wr = 1'b0;
   logic sb_rd = 1'b0;
   logic [31:0] sb_wdata = 32'h0;
   logic [31:0] sb_rdata;
   logic scl_o, scl_oe, sda_o, sda_oe, scl_low, sda_low, irq_b, smi_n, wake, cfg_dis, pg_req, slp;
   logic tb_sda_low = 1'b0;
   logic alert_n = 1'b1;
   logic route = 1'b0;
   logic wake_clr = 1'b0;
   logic wd_evt = 1'b0;
   logic [2:0] wd_sel = 3'h0;
   logic pg_cond = 1'b0;
   logic [7:0] wd_lines;
   logic [7:0] msg [4];
   int bad_count = 0;
   int check_count = 0;
   int acks;
   // open-drain lines with pull-ups
   wire scl_w = !(scl_low || scl_oe);
   wire sda_w = !(sda_low || sda_oe || tb_sda_low);
   always #50 clk_sys = ~clk_sys;
   snpc_top #(.TICK_DIV(TDIV)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .resume_well_rst_n(rsm_n),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .sb_addr(sb_addr), .sb_wr(sb_wr), .sb_rd(sb_rd), .sb_wdata(sb_wdata), .sb_rdata(sb_rdata),
      .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .alert_n_i(alert_n), .mgmt_irq_route_sel(route), .shared_irq_line_b(irq_b),
      .system_mgmt_irq_n(smi_n), .other_wake_evt(1'b0), .bus_wake_clr(wake_clr), .bus_wake_flag(wake),
      .watchdog_evt(wd_evt), .watchdog_irq_select(wd_sel), .watchdog_irq_lines(wd_lines),
      .cfg_space_disable(cfg_dis), .pg_conditions_met(pg_cond), .power_gate_req(pg_req),
      .sleep_assert(slp));
   snpc_bus_dev dev_u (.scl_low(scl_low), .sda_low(sda_low), .sda(sda_w));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // one-cycle strobes; read data taken the cycle after
   task automatic io_w(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      cyc(1);
      io_wr = 1'b0;
   endtask
   task automatic io_chk(input string n, input logic [7:0] a, input logic [7:0] e);
      cyc(1);
      io_addr = a;
      io_rd = 1'b1;
      cyc(1);
      io_rd = 1'b0;
      chk(n, {24'h0, e}, {24'h0, io_rdata});
   endtask
   task automatic sb_w(input logic [7:0] a, input logic [31:0] d);
      cyc(1);
      sb_addr = a;
      sb_wdata = d;
      sb_wr = 1'b1;
      cyc(1);
      sb_wr = 1'b0;
      cyc(3);
   endtask
   task automatic sb_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      cyc(1);
      sb_addr = a;
      sb_rd = 1'b1;
      cyc(1);
      sb_rd = 1'b0;
      chk(n, e, sb_rdata);
   endtask
   // slow-domain write, then wait for the tick
   task automatic slow_w(input logic [7:0] a, input logic [7:0] d);
      io_w(a, d);
      cyc(2 * TDIV + 2);
   endtask
   task automatic t_reset();
      io_chk("pin reset", 8'h0F, 8'h07);
      io_chk("cmd reset", 8'h11, 8'h00);
      io_chk("unmapped io", 8'h30, 8'h00);
      sb_chk("wdt reset", 8'h00, 32'h0);
      sb_chk("gc reset", 8'h0C, 32'h0);
      sb_chk("pwr reset", 8'h10, 32'h9);
      $display("test reset done");
   endtask
   task automatic t_pin();
      tb_sda_low = 1'b1;
      cyc(4);
      io_chk("data low", 8'h0F, 8'h05);
      tb_sda_low = 1'b0;
      io_w(8'h0F, 8'h00);
      cyc(4);
      chk("clock pulled", 1, scl_oe);
      io_chk("clock low", 8'h0F, 8'h02);
      nrst = 1'b0;
      cyc(2);
      nrst = 1'b1;
      cyc(2);
      chk("override kept", 1, scl_oe);
      rsm_n = 1'b0;
      cyc(2);
      rsm_n = 1'b1;
      cyc(4);
      chk("override reset", 0, scl_oe);
      io_chk("pin after resume", 8'h0F, 8'h07);
      $display("test pin done");
   endtask
   task automatic t_notify();
      slow_w(8'h11, 8'h03);
      io_chk("cmd set", 8'h11, 8'h03);
      msg = '{8'h10, 8'hB5, 8'h3C, 8'hC3};
      dev_u.send(msg, acks);
      cyc(4);
      chk("acks", 4, acks);
      io_chk("flag set", 8'h10, 8'h01);
      io_chk("addr", 8'h14, 8'hB4);
      io_chk("low byte", 8'h16, 8'h3C);
      io_chk("high byte", 8'h17, 8'hC3);
      chk("irq b", 1, irq_b);
      chk("wake", 1, wake);
      wake_clr = 1'b1;
      cyc(1);
      wake_clr = 1'b0;
      cyc(1);
      chk("wake cleared", 0, wake);
      route = 1'b1;
      cyc(3);
      chk("smi", 0, smi_n);
      chk("irq b off", 0, irq_b);
      route = 1'b0;
      $display("test notify done");
   endtask
   task automatic t_refuse();
      msg = '{8'h10, 8'h22, 8'h11, 8'h99};
      dev_u.send(msg, acks);
      chk("refused acks", 0, acks);
      io_chk("addr kept", 8'h14, 8'hB4);
      io_chk("low kept", 8'h16, 8'h3C);
      slow_w(8'h10, 8'h00);
      io_chk("flag kept", 8'h10, 8'h01);
      slow_w(8'h10, 8'h01);
      io_chk("flag cleared", 8'h10, 8'h00);
      chk("irq off", 0, irq_b);
      slow_w(8'h11, 8'h00);
      dev_u.send(msg, acks);
      cyc(4);
      io_chk("flag no enable", 8'h10, 8'h01);
      io_chk("addr renewed", 8'h14, 8'h22);
      chk("acks again", 4, acks);
      chk("irq gated", 0, irq_b);
      chk("no wake", 0, wake);
      slow_w(8'h11, 8'h01);
      chk("irq at once", 1, irq_b);
      slow_w(8'h11, 8'h00);
      alert_n = 1'b0;
      cyc(4);
      chk("alert irq", 1, irq_b);
      slow_w(8'h11, 8'h04);
      chk("alert blocked", 0, irq_b);
      alert_n = 1'b1;
      $display("test refuse done");
   endtask
   task automatic t_side();
      sb_w(8'h00, 32'h80);
      wd_evt = 1'b1;
      wd_sel = 3'h5;
      cyc(3);
      chk("wdt line", 8'h20, wd_lines);
      sb_w(8'h00, 32'h0);
      chk("wdt off", 8'h00, wd_lines);
      wd_evt = 1'b0;
      sb_w(8'h0C, 32'h1);
      chk("cfg off", 1, cfg_dis);
      sb_chk("unaligned", 8'h0D, 32'h0);
      sb_chk("unmapped sb", 8'h20, 32'h0);
      sb_w(8'h10, 32'hF);
      sb_chk("pwr ro bits", 8'h10, 32'h9);
      pg_cond = 1'b1;
      cyc(3);
      chk("pg req", 1, pg_req);
      chk("sleep", 1, slp);
      sb_w(8'h10, 32'h1);
      chk("sleep off", 0, slp);
      sb_w(8'h10, 32'h0);
      chk("pg off", 0, pg_req);
      pg_cond = 1'b0;
      $display("test sideband done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // main sequence after four reset cycles
   initial begin
      cyc(4);
      nrst = 1'b1;
      rsm_n = 1'b1;
      t_reset();
      t_pin();
      t_notify();
      t_refuse();
      t_side();
      complete_run();
   end
   // hang guard, well past the expected run
   initial begin
      #2000000;
      bad_count++;
      complete_run();
   end
endmodule
bind snpc_top snpc_assertions #(.TICK_DIV(TICK_DIV)) chk_u (.clk_sys(clk_sys), .nrst(nrst),
   .resume_well_rst_n(resume_well_rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata),
   .sb_addr(sb_addr), .sb_wr(sb_wr), .sb_rd(sb_rd), .sb_wdata(sb_wdata), .sb_rdata(sb_rdata),
   .scl_o(scl_o), .sda_o(sda_o), .scl_oe(scl_oe), .sda_oe(sda_oe), .shared_irq_line_b(shared_irq_line_b),
   .system_mgmt_irq_n(system_mgmt_irq_n), .watchdog_evt(watchdog_evt),
   .watchdog_irq_select(watchdog_irq_select), .watchdog_irq_lines(watchdog_irq_lines),
   .cfg_space_disable(cfg_space_disable), .pg_conditions_met(pg_conditions_met),
   .power_gate_req(power_gate_req), .sleep_assert(sleep_assert));
